//--- src/scpwm_pkg.sv
// Purpose: Shared constants and types for the six channel PWM timer
// Assumes: Avalon-MM byte addresses, one register per aligned 32-bit word
// Notes:   Register byte address is four times the register index
package scpwm_pkg;

   // Register indices; byte address = index * 4
   localparam logic [7:0] IDX_MODE       = 8'hab;
   localparam logic [7:0] IDX_PERIOD_LO  = 8'hac;
   localparam logic [7:0] IDX_PERIOD_HI  = 8'had;
   localparam logic [7:0] IDX_BOUND_LO   = 8'hae;
   localparam logic [7:0] IDX_BOUND_HI   = 8'haf;
   localparam logic [7:0] IDX_DUTY_LO    = 8'hbb;
   localparam logic [7:0] IDX_DUTY_HI    = 8'hbc;
   localparam logic [7:0] IDX_LEAD       = 8'hbd;
   localparam logic [7:0] IDX_CHAN_SEL   = 8'hbe;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'hc0;
   localparam logic [7:0] IDX_IRQ_MASK   = 8'hc1;
   localparam logic [7:0] IDX_IRQ_CTRL   = 8'hd1;

   // Field positions
   localparam int         CH_GRP2_LSB    = 4;
   localparam int         CH_GRP1_LSB    = 0;
   localparam int         IRQC_ENABLE    = 7;
   localparam int         IRQC_FLAG      = 3;
   localparam int         IRQ_OVF        = 0;

   // Reset value and full prescaler mask
   localparam logic [7:0] RST_BYTE       = 8'h00;
   localparam logic [6:0] PRESC_FULL     = 7'h7f;

   // Mode register layout
   typedef struct packed {
      logic       enable;
      logic [2:0] prescale_code;
      logic       grp2_invert;
      logic       grp1_invert;
      logic       comparator_sync_enable;
      logic       single_pulse_mode;
   } scpwm_mode_t;

   // Timer configuration bundle
   typedef struct packed {
      logic [15:0] period_value;
      logic [15:0] duty_value;
      logic [15:0] deadband_bound;
      logic [7:0]  deadband_lead_value;
   } scpwm_cfg_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_RUN   = 3'b010,
      ST_STALL = 3'b100
   } scpwm_state_t;

endpackage

//--- src/scpwm_timer.sv
// Function
// - Select bits 6..4 hand group-two pins to the timer when set, else GPIO.
// - Select bits 2..0 hand group-one pins to the timer when set, else GPIO.
// - Prescale code 000 divides by 128, halving per step, 111 divides by one.
// - Mode bit 3 inverts the three group-two outputs.
// - Mode bit 2 inverts the three group-one outputs.
// - Mode bit 1 lets comparator events start and stop outputs, else ignored.
// - Sixteen-bit period in two byte registers sets the terminal count.
// - Sixteen-bit duty in two byte registers ends the high phase.
// - Sixteen-bit dead-band bound in two bytes sets the trailing dead edge.
// - Enabling with zero period stalls the timer and blocks period writes.
// - Output high at count zero, low at duty match, wrap after period.
// - Single-pulse mode yields one period, then enable self-clears.
// - Overflow from period minus one sets a software readable flag.
// - Dead band is cut from the high pulse; too long means no pulse.
//
// Purpose: Six channel 16-bit up-counting PWM timer with Avalon-MM registers
// Assumes: Comparator start/stop arrive as one-cycle pulses in this clock
// Notes:   Register reads answer after exactly one wait cycle
`timescale 1ns/1ps
module scpwm_timer
   import scpwm_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_reset_n,
   input  wire logic [9:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire logic        i_cmp_start,
   input  wire logic        i_cmp_stop,
   output logic      [5:0]  o_pin_wave,
   output logic      [5:0]  o_pin_sel,
   output logic             o_irq
);

   // Register state
   scpwm_mode_t  mode_q,      mode_d;
   scpwm_cfg_t   cfg_q,       cfg_d;
   logic [7:0]   chan_sel_q,  chan_sel_d;
   logic         irq_stat_q,  irq_stat_d;
   logic         irq_mask_q,  irq_mask_d;
   logic         wait_q,      wait_d;
   logic [31:0]  rdata_q,     rdata_d;
   logic         irq_q,       irq_d;

   // Timer state
   scpwm_state_t state_q,     state_d;
   logic [6:0]   presc_q,     presc_d;
   logic [15:0]  count_q,     count_d;
   logic         gate_q,      gate_d;
   logic [5:0]   wave_q,      wave_d;
   logic [5:0]   sel_q,       sel_d;

   logic         ovf_evt;
   logic         oneshot_clr;
   logic         tick;
   logic         req_take;
   logic         wr_take;
   logic [7:0]   reg_idx;
   logic         addr_ok;
   logic         wave_act;

   // Divider mask: all ones means divide by 128, zero mask means every clock
   function automatic logic [6:0] presc_mask(input logic [2:0] code);
      presc_mask = PRESC_FULL >> code;
   endfunction

   // Read mux over the documented and added registers
   function automatic logic [7:0] reg_read(input logic [7:0] idx,
                                           input scpwm_mode_t m,
                                           input scpwm_cfg_t c,
                                           input logic [7:0] ch,
                                           input logic st,
                                           input logic mk);
      reg_read = RST_BYTE;
      unique case (idx)
         IDX_MODE:       reg_read = m;
         IDX_PERIOD_LO:  reg_read = c.period_value[7:0];
         IDX_PERIOD_HI:  reg_read = c.period_value[15:8];
         IDX_BOUND_LO:   reg_read = c.deadband_bound[7:0];
         IDX_BOUND_HI:   reg_read = c.deadband_bound[15:8];
         IDX_DUTY_LO:    reg_read = c.duty_value[7:0];
         IDX_DUTY_HI:    reg_read = c.duty_value[15:8];
         IDX_LEAD:       reg_read = c.deadband_lead_value;
         IDX_CHAN_SEL:   reg_read = ch;
         IDX_IRQ_STATUS: reg_read[IRQ_OVF] = st;
         IDX_IRQ_MASK:   reg_read[IRQ_OVF] = mk;
         IDX_IRQ_CTRL: begin
            reg_read[IRQC_ENABLE] = mk;
            reg_read[IRQC_FLAG]   = st;
         end
         default:        reg_read = RST_BYTE;
      endcase
   endfunction

   // Bus decode: request taken while waitrequest is high, acted on when low
   assign reg_idx  = i_avs_address[9:2];
   assign addr_ok  = (i_avs_address[1:0] == 2'b00);
   assign req_take = (i_avs_read | i_avs_write) & wait_q;
   assign wr_take  = i_avs_write & ~wait_q & addr_ok;

   // Prescaler tick
   assign tick = ((presc_q & presc_mask(mode_q.prescale_code))
                  == presc_mask(mode_q.prescale_code));

   // Overflow when count steps from period minus one back to zero
   assign ovf_evt = (state_q == ST_RUN) & tick
                    & (count_q == cfg_q.period_value - 16'h0001);
   assign oneshot_clr = ovf_evt & mode_q.single_pulse_mode;

   // Active phase: lead dead time, then high until bound, never past duty
   assign wave_act = (count_q < cfg_q.duty_value)
                     & (count_q >= {8'h00, cfg_q.deadband_lead_value})
                     & (count_q < cfg_q.deadband_bound);

   // Register next values; hardware sets win over software clears
   always_comb begin
      mode_d     = mode_q;
      cfg_d      = cfg_q;
      chan_sel_d = chan_sel_q;
      irq_mask_d = irq_mask_q;
      irq_stat_d = irq_stat_q;
      wait_d     = ~req_take;
      rdata_d    = rdata_q;
      // Only reads refresh the data word, so software may poll it late
      if (req_take && i_avs_read) begin
         rdata_d = addr_ok ? {24'h000000, reg_read(reg_idx, mode_q, cfg_q, chan_sel_q,
                                                   irq_stat_q, irq_mask_q)} : 32'h00000000;
      end
      if (oneshot_clr) begin
         mode_d.enable = 1'b0;
      end
      if (wr_take) begin
         unique case (reg_idx)
            IDX_MODE:      mode_d = scpwm_mode_t'(i_avs_writedata[7:0]);
            IDX_PERIOD_LO: begin
               if (state_q != ST_STALL) begin
                  cfg_d.period_value[7:0] = i_avs_writedata[7:0];
               end
            end
            IDX_PERIOD_HI: begin
               if (state_q != ST_STALL) begin
                  cfg_d.period_value[15:8] = i_avs_writedata[7:0];
               end
            end
            IDX_BOUND_LO:  cfg_d.deadband_bound[7:0]  = i_avs_writedata[7:0];
            IDX_BOUND_HI:  cfg_d.deadband_bound[15:8] = i_avs_writedata[7:0];
            IDX_DUTY_LO:   cfg_d.duty_value[7:0]      = i_avs_writedata[7:0];
            IDX_DUTY_HI:   cfg_d.duty_value[15:8]     = i_avs_writedata[7:0];
            IDX_LEAD:      cfg_d.deadband_lead_value  = i_avs_writedata[7:0];
            IDX_CHAN_SEL:  chan_sel_d = i_avs_writedata[7:0];
            IDX_IRQ_STATUS: begin
               if (i_avs_writedata[IRQ_OVF]) begin
                  irq_stat_d = 1'b0;
               end
            end
            IDX_IRQ_MASK:  irq_mask_d = i_avs_writedata[IRQ_OVF];
            IDX_IRQ_CTRL: begin
               irq_mask_d = i_avs_writedata[IRQC_ENABLE];
               irq_stat_d = i_avs_writedata[IRQC_FLAG];
            end
            default: ;
         endcase
      end
      // Set placed last so an overflow is never lost to a same-cycle clear
      if (ovf_evt) begin
         irq_stat_d = 1'b1;
      end
      irq_d = irq_stat_d & irq_mask_d;
   end

   // Register bank flops
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         mode_q     <= scpwm_mode_t'(RST_BYTE);
         cfg_q      <= '0;
         chan_sel_q <= RST_BYTE;
         irq_stat_q <= 1'b0;
         irq_mask_q <= 1'b0;
         wait_q     <= 1'b1;
         rdata_q    <= 32'h00000000;
         irq_q      <= 1'b0;
      end else begin
         mode_q     <= mode_d;
         cfg_q      <= cfg_d;
         chan_sel_q <= chan_sel_d;
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
         wait_q     <= wait_d;
         rdata_q    <= rdata_d;
         irq_q      <= irq_d;
      end
   end

   // Timer sequencing, comparator gate and pin outputs
   always_comb begin
      state_d = state_q;
      presc_d = presc_q + 7'h01;
      count_d = count_q;
      gate_d  = gate_q;
      wave_d  = wave_q;
      sel_d   = sel_q;
      unique case (state_q)
         ST_IDLE: begin
            presc_d = 7'h00;
            count_d = 16'h0000;
            if (mode_q.enable) begin
               // Zero period parks the timer until enable drops
               state_d = (cfg_q.period_value == 16'h0000) ? ST_STALL : ST_RUN;
            end
         end
         ST_RUN: begin
            if (!mode_q.enable) begin
               state_d = ST_IDLE;
            end else if (tick) begin
               count_d = ovf_evt ? 16'h0000 : count_q + 16'h0001;
               if (oneshot_clr) begin
                  state_d = ST_IDLE;
               end
            end
         end
         ST_STALL: begin
            presc_d = 7'h00;
            if (!mode_q.enable) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase

      // Comparator gating only while sync is enabled; otherwise always open
      if (!mode_q.comparator_sync_enable) begin
         gate_d = 1'b1;
      end else if (i_cmp_stop) begin
         gate_d = 1'b0;
      end else if (i_cmp_start) begin
         gate_d = 1'b1;
      end

      // Pins leave the timer when disabled; GPIO keeps its own last state
      if (state_q == ST_RUN && mode_q.enable) begin
         sel_d[2:0] = chan_sel_q[CH_GRP1_LSB +: 3];
         sel_d[5:3] = chan_sel_q[CH_GRP2_LSB +: 3];
      end else begin
         sel_d = 6'h00;
      end
      wave_d[2:0] = {3{(wave_act & gate_q) ^ mode_q.grp1_invert}};
      wave_d[5:3] = {3{(wave_act & gate_q) ^ mode_q.grp2_invert}};
   end

   // Timer flops
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         state_q <= ST_IDLE;
         presc_q <= 7'h00;
         count_q <= 16'h0000;
         gate_q  <= 1'b1;
         wave_q  <= 6'h00;
         sel_q   <= 6'h00;
      end else begin
         state_q <= state_d;
         presc_q <= presc_d;
         count_q <= count_d;
         gate_q  <= gate_d;
         wave_q  <= wave_d;
         sel_q   <= sel_d;
      end
   end

   assign o_avs_readdata    = rdata_q;
   assign o_avs_waitrequest = wait_q;
   assign o_pin_wave        = wave_q;
   assign o_pin_sel         = sel_q;
   assign o_irq             = irq_q;

endmodule // scpwm_timer

//--- verification/scpwm_cmp_model.sv
// Purpose: Comparator event source on the far side of the timer
// Assumes: Events are one-cycle pulses in the system clock
// Notes:   Silent until the bench asks for an event
`timescale 1ns/1ps
module scpwm_cmp_model (
   input  wire logic i_sys_clk,
   output logic      o_cmp_start = 1'b0,
   output logic      o_cmp_stop  = 1'b0
);
   // One pulse, raised and dropped just after clock edges
   task automatic fire(input logic stop);
      @(posedge i_sys_clk);
      o_cmp_stop  <= stop;
      o_cmp_start <= !stop;
      @(posedge i_sys_clk);
      o_cmp_stop  <= 1'b0;
      o_cmp_start <= 1'b0;
   endtask
endmodule // scpwm_cmp_model

//--- verification/scpwm_chk.sv
// Purpose: Bus handshake and pin ownership relations of the timer
// Assumes: One clock, synchronous active-low reset
// Notes:   Attached by the bind below the module
`timescale 1ns/1ps
module scpwm_chk
   import scpwm_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_reset_n,
   input  wire logic [9:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [31:0] o_avs_readdata,
   input  wire logic        o_avs_waitrequest,
   input  wire logic [5:0]  o_pin_sel,
   input  wire logic        o_irq
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   // Request taken, and a write completing at one register
   sequence s_req;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   sequence s_wr(logic [7:0] idx);
      i_avs_write && !o_avs_waitrequest && i_avs_address == {idx, 2'b00};
   endsequence
   // Answer one cycle after the take, for exactly one cycle
   property p_ans;
      s_req |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
   endproperty
   property p_idle;
      !(i_avs_read || i_avs_write) && o_avs_waitrequest |=> o_avs_waitrequest;
   endproperty
   property p_upper;
      !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0;
   endproperty
   property p_unal;
      s_req ##0 (i_avs_read && i_avs_address[1:0] != 2'h0) |=> o_avs_readdata == 32'h0;
   endproperty
   // Read data must not drift between reads, software may poll late
   property p_hold;
      !i_avs_read |=> $stable(o_avs_readdata);
   endproperty
   property p_sel_off;
      s_wr(IDX_CHAN_SEL) ##0 (i_avs_writedata[6:0] & 7'h77) == 7'h0 |-> ##2 o_pin_sel == 6'h0;
   endproperty
   property p_dis;
      s_wr(IDX_MODE) ##0 !i_avs_writedata[7] |-> ##2 (o_pin_sel == 6'h0) [*2];
   endproperty
   property p_mask;
      s_wr(IDX_IRQ_MASK) ##0 !i_avs_writedata[IRQ_OVF] |-> ##2 !o_irq [*3];
   endproperty
   a_ans: assert property (p_ans) else $error("bus answer not one cycle after take");
   a_idle: assert property (p_idle) else $error("answer without request");
   a_upper: assert property (p_upper) else $error("read data upper bits set");
   a_unal: assert property (p_unal) else $error("unaligned read not zero");
   a_hold: assert property (p_hold) else $error("read data changed without read");
   a_sel_off: assert property (p_sel_off) else $error("pin kept after deselect");
   a_dis: assert property (p_dis) else $error("pin kept after disable");
   a_mask: assert property (p_mask) else $error("masked interrupt raised");
endmodule // scpwm_chk

bind scpwm_timer scpwm_chk i_chk (
   .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .o_pin_sel(o_pin_sel), .o_irq(o_irq)
);

//--- verification/tb_scpwm_timer.sv
// Purpose: Self-checking bench for the six channel PWM timer
// Assumes: Waveforms judged by high-cycle counts over whole periods
// Notes:   Prescale codes 111, 110 and 000 probe the divider chain
`timescale 1ns/1ps
module tb_scpwm_timer
   import scpwm_pkg::*;
;
   localparam logic [7:0] REGS [9] = '{IDX_MODE, IDX_PERIOD_LO, IDX_PERIOD_HI,
      IDX_BOUND_LO, IDX_BOUND_HI, IDX_DUTY_LO, IDX_DUTY_HI, IDX_LEAD, IDX_CHAN_SEL};
   logic        clk     = 1'b0;
   logic        rst_n   = 1'b0;
   logic [9:0]  addr    = 10'h0;
   logic        rd      = 1'b0;
   logic        wr      = 1'b0;
   logic [31:0] wdata   = 32'h0;
   logic [31:0] rdata;
   logic        waitreq;
   logic        cmp_start;
   logic        cmp_stop;
   logic [5:0]  wave;
   logic [5:0]  sel;
   logic        irq;
   logic [31:0] rd_val;
   int          err_total = 0;
   int          n_tests   = 0;
   // 25 MHz system clock
   always #20 clk = ~clk;
   scpwm_timer i_dut (
      .i_sys_clk(clk), .i_reset_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
      .o_avs_waitrequest(waitreq), .i_cmp_start(cmp_start), .i_cmp_stop(cmp_stop),
      .o_pin_wave(wave), .o_pin_sel(sel), .o_irq(irq)
   );
   scpwm_cmp_model i_cmp (.i_sys_clk(clk), .o_cmp_start(cmp_start), .o_cmp_stop(cmp_stop));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask
   // Avalon cycle: request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d = 8'h00,
                      input logic [1:0] lo = 2'h0);
      int k;
      @(posedge clk);
      addr  <= {idx, lo};
      wr    <= w;
      rd    <= !w;
      wdata <= {24'h0, d};
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (waitreq === 1'b0)
            break;
      end
      rd_val = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      if (k == 20) begin
         err_total++;
         tally_and_finish();
      end
   endtask
   task automatic w16(input logic [7:0] idx, input logic [15:0] v);
      bus(1'b1, idx, v[7:0]);
      bus(1'b1, idx + 8'h01, v[15:8]);
   endtask
   // Stop, load both period bytes first, then start
   task automatic cfg(input logic [15:0] per, dty, bnd, input logic [7:0] ld, md);
      bus(1'b1, IDX_MODE, 8'h00);
      w16(IDX_PERIOD_LO, per);
      w16(IDX_DUTY_LO, dty);
      w16(IDX_BOUND_LO, bnd);
      bus(1'b1, IDX_LEAD, ld);
      bus(1'b1, IDX_MODE, md);
      repeat (6) @(posedge clk);
   endtask
   // High cycles of one pin over n clocks
   task automatic meas(input int b, input int n, input int exp);
      int h;
      h = 0;
      repeat (n) begin
         @(posedge clk);
         h += (wave[b] === 1'b1);
      end
      chk($sformatf("wave%0d highs", b), exp, h);
   endtask
   task automatic t_regs;
      foreach (REGS[i]) begin
         bus(1'b0, REGS[i]);
         chk("reset value", 32'h0, rd_val);
         bus(1'b1, REGS[i], 8'h77);
         bus(1'b0, REGS[i]);
         chk("readback", 32'h77, rd_val);
      end
      bus(1'b1, 8'hff, 8'h5a);
      bus(1'b0, 8'hff);
      chk("unmapped", 32'h0, rd_val);
      bus(1'b0, IDX_MODE, 8'h00, 2'h2);
      chk("unaligned", 32'h0, rd_val);
   endtask
   task automatic t_wave;
      cfg(16'h8, 16'h3, 16'hffff, 8'h0, 8'hf0);
      chk("sel", 32'h3f, sel);
      meas(0, 16, 6);
      meas(5, 16, 6);
      cfg(16'h8, 16'h3, 16'hffff, 8'h0, 8'hf4);
      meas(0, 16, 10);
      meas(3, 16, 6);
      cfg(16'h8, 16'h3, 16'hffff, 8'h0, 8'he0);
      meas(0, 32, 12);
      cfg(16'h2, 16'h1, 16'hffff, 8'h0, 8'h80);
      repeat (300) @(posedge clk);
      meas(0, 512, 256);
   endtask
   task automatic t_chan;
      cfg(16'h8, 16'h3, 16'hffff, 8'h0, 8'hf0);
      bus(1'b1, IDX_CHAN_SEL, 8'h05);
      repeat (3) @(posedge clk);
      chk("sel group one", 32'h05, sel);
      bus(1'b1, IDX_CHAN_SEL, 8'h50);
      repeat (3) @(posedge clk);
      chk("sel group two", 32'h28, sel);
      bus(1'b1, IDX_CHAN_SEL, 8'h00);
      bus(1'b1, IDX_CHAN_SEL, 8'h77);
      bus(1'b1, IDX_MODE, 8'h00);
      repeat (3) @(posedge clk);
      chk("sel off", 32'h0, sel);
   endtask
   task automatic t_dead;
      cfg(16'h8, 16'h4, 16'h2, 8'h0, 8'hf0);
      meas(0, 16, 4);
      cfg(16'h8, 16'h4, 16'hffff, 8'h6, 8'hf0);
      meas(0, 16, 0);
   endtask
   task automatic t_pulse;
      bus(1'b1, IDX_MODE, 8'h00);
      bus(1'b1, IDX_IRQ_STATUS, 8'h01);
      bus(1'b1, IDX_IRQ_MASK, 8'h01);
      cfg(16'h8, 16'h3, 16'hffff, 8'h0, 8'hf1);
      repeat (12) @(posedge clk);
      bus(1'b0, IDX_MODE);
      chk("mode after pulse", 32'h71, rd_val);
      chk("sel after pulse", 32'h0, sel);
      chk("irq", 32'h1, irq);
      bus(1'b0, IDX_IRQ_CTRL);
      chk("irq ctrl", 32'h88, rd_val);
      bus(1'b1, IDX_IRQ_MASK, 8'h00);
      repeat (3) @(posedge clk);
      chk("irq masked", 32'h0, irq);
      bus(1'b1, IDX_IRQ_MASK, 8'h01);
      bus(1'b1, IDX_IRQ_STATUS, 8'h01);
      repeat (3) @(posedge clk);
      chk("irq cleared", 32'h0, irq);
   endtask
   task automatic t_cmp;
      cfg(16'h8, 16'h3, 16'hffff, 8'h0, 8'hf0);
      i_cmp.fire(1'b1);
      meas(0, 16, 6);
      cfg(16'h8, 16'h3, 16'hffff, 8'h0, 8'hf2);
      i_cmp.fire(1'b1);
      repeat (10) @(posedge clk);
      meas(0, 16, 0);
      i_cmp.fire(1'b0);
      repeat (10) @(posedge clk);
      meas(0, 16, 6);
   endtask
   task automatic t_stall;
      cfg(16'h0, 16'h3, 16'hffff, 8'h0, 8'hf0);
      w16(IDX_PERIOD_LO, 16'h0505);
      bus(1'b0, IDX_PERIOD_LO);
      chk("stalled period", 32'h0, rd_val);
   endtask
   // Main sequence: reset, then one scenario per task
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      chk("idle waitrequest", 32'h1, waitreq);
      t_regs();
      t_wave();
      t_chan();
      t_dead();
      t_pulse();
      t_cmp();
      t_stall();
      tally_and_finish();
   end
endmodule // tb_scpwm_timer
